//--- shared/uart_fcr_isr_defs.svh
// register offsets, field positions, reset values, codes and trigger tables
`ifndef UART_FCTL_ISR_DEFS_SVH
`define UART_FCTL_ISR_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------------------
`define OFS_ISR        8'h00
`define OFS_FCTL       8'h04
`define OFS_FEAT       8'h08
`define OFS_ENH        8'h0c
`define OFS_RXLVL      8'h10
`define OFS_TXLVL      8'h14
`define REG_RST        8'h00
`define READ_ZERO      32'h0000_0000

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FCTL_EN        0
`define FCTL_RXRST     1
`define FCTL_TXRST     2
`define FCTL_DMA       3
`define FCTL_TXT       5:4
`define FCTL_RXT       7:6
`define FCTL_HOLD      7:3
`define FEAT_TBL       7:6
`define ENH_BIT        4
`define BYTE0          7:0
`define LANE0          0

// ----------------------------------------------------------------------------
// interrupt status codes, bits 5..0, and fifo-enable field
// ----------------------------------------------------------------------------
`define ISR_LSR        6'h06
`define ISR_RXDAT      6'h04
`define ISR_RXTO       6'h0c
`define ISR_TXE        6'h02
`define ISR_MSR        6'h00
`define ISR_SPEC       6'h10
`define ISR_FLOW       6'h20
`define ISR_NONE       6'h01
`define ISR_FIFO_ON    2'h3
`define ISR_FIFO_OFF   2'h0

// ----------------------------------------------------------------------------
// trigger table selections and levels
// ----------------------------------------------------------------------------
`define TBL_A          2'h0
`define TBL_B          2'h1
`define TBL_C          2'h2
`define TBL_D          2'h3
`define TRIG_ONE       7'h01
`define TA_RX          {7'h0e, 7'h08, 7'h04, 7'h01}
`define TB_TX          {7'h1e, 7'h18, 7'h08, 7'h10}
`define TB_RX          {7'h1c, 7'h18, 7'h10, 7'h08}
`define TC_TX          {7'h38, 7'h20, 7'h10, 7'h08}
`define TC_RX          {7'h3c, 7'h38, 7'h10, 7'h08}
`define LEVEL_ZERO     7'h00
`define FIFO_DEPTH_DOC 64

`endif

//--- shared/uart_fcr_isr_pkg.sv
// types shared by the status/control block and its helpers
package uart_fctl_isr_pkg;

  // pending interrupt sources, highest priority first
  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem;
    logic special;
    logic flow;
  } int_src_s;

  // software-visible trigger selections
  typedef struct packed {
    logic [1:0] table_sel;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic [7:0] rx_prog;
    logic [7:0] tx_prog;
  } trig_cfg_s;

endpackage

//--- core/trig_select.sv
// trigger level lookup over the four tables
`timescale 1ns/1ps
`default_nettype none
`include "uart_fcr_isr_defs.svh"

module trig_select #(
  parameter int LEVEL_W = 7
) (
  input  wire logic                       clk_i,    // clock
  input  wire logic                       rst_i,    // sync reset
  input  wire uart_fctl_isr_pkg::trig_cfg_s cfg_i,  // table and selections
  input  wire logic                       fifo_en_i, // fifos enabled
  output logic [LEVEL_W-1:0]              rx_trig_o, // receive trigger
  output logic [LEVEL_W-1:0]              tx_trig_o  // transmit trigger
);

  // one lookup serves both directions; a single table field keeps them aligned
  function automatic logic [6:0] pick(input logic [27:0] tbl, input logic [1:0] sel);
    pick = tbl[sel*7 +: 7];
  endfunction

  logic [6:0] rx_doc;
  logic [6:0] tx_doc;

  // table decode, table d takes the programmable registers
  assign rx_doc = (cfg_i.table_sel == `TBL_A) ? pick(`TA_RX, cfg_i.rx_sel) :
                  (cfg_i.table_sel == `TBL_B) ? pick(`TB_RX, cfg_i.rx_sel) :
                  (cfg_i.table_sel == `TBL_C) ? pick(`TC_RX, cfg_i.rx_sel) :
                  cfg_i.rx_prog[6:0];
  assign tx_doc = (cfg_i.table_sel == `TBL_A) ? `TRIG_ONE :
                  (cfg_i.table_sel == `TBL_B) ? pick(`TB_TX, cfg_i.tx_sel) :
                  (cfg_i.table_sel == `TBL_C) ? pick(`TC_TX, cfg_i.tx_sel) :
                  cfg_i.tx_prog[6:0];

  // registered outputs; non-fifo mode behaves as a one-deep holding register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_trig_o <= LEVEL_W'(`TRIG_ONE);
      tx_trig_o <= LEVEL_W'(`TRIG_ONE);
    end else begin
      rx_trig_o <= fifo_en_i ? LEVEL_W'(rx_doc) : LEVEL_W'(`TRIG_ONE);
      tx_trig_o <= fifo_en_i ? LEVEL_W'(tx_doc) : LEVEL_W'(`TRIG_ONE);
    end
  end

endmodule // trig_select
`default_nettype wire

//--- core/isr_encoder.sv
// priority encoder for the interrupt source status byte
`timescale 1ns/1ps
`default_nettype none
`include "uart_fcr_isr_defs.svh"

module isr_encoder (
  input  wire logic                       clk_i,     // clock
  input  wire logic                       rst_i,     // sync reset
  input  wire uart_fctl_isr_pkg::int_src_s src_i,    // pending sources
  input  wire logic                       enh_en_i,  // enhanced functions on
  input  wire logic                       fifo_en_i, // fifos enabled
  output logic [7:0]                      isr_o      // status byte
);

  logic [5:0] code;
  logic [1:0] fifo_bits;

  // highest level wins; the two enhanced sources only count when enabled
  assign code = src_i.line_status          ? `ISR_LSR   :
                src_i.rx_data              ? `ISR_RXDAT :
                src_i.rx_timeout           ? `ISR_RXTO  :
                src_i.tx_empty             ? `ISR_TXE   :
                src_i.modem                ? `ISR_MSR   :
                (src_i.special & enh_en_i) ? `ISR_SPEC  :
                (src_i.flow & enh_en_i)    ? `ISR_FLOW  :
                `ISR_NONE;
  assign fifo_bits = fifo_en_i ? `ISR_FIFO_ON : `ISR_FIFO_OFF;

  // reset shows no interrupt pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_o <= {`ISR_FIFO_OFF, `ISR_NONE};
    end else begin
      isr_o <= {fifo_bits, code};
    end
  end

endmodule // isr_encoder
`default_nettype wire

//--- core/uart_fcr_isr.sv
// interrupt source status and fifo control registers of one serial channel
`timescale 1ns/1ps
`default_nettype none
`include "uart_fcr_isr_defs.svh"

// Notes on behaviour
// - status bit 0 low while interrupt pending
// - status bits 3..1 encode source levels one-four
// - status bits 5,4 only with enhanced enable
// - xon/xoff match sticky until xon received
// - flow pin change sets status bit 5
// - status bits 7,6 mirror fifo enable
// - control bit 0 enables both fifos
// - other control bits ignored unless bit 0
// - bit 1 clears receive fifo, self-clears
// - bit 2 clears transmit fifo, self-clears
// - dma mode bit stored only, no effect
// - transmit interrupt when level below trigger
// - otherwise transmit interrupt when fifo empties
// - control bits 7,6 pick receive trigger
// - one common table for both directions
// - table a: rx 1,4,8,14, tx 1
// - table b: tx 16,8,24,30 rx 8,16,24,28
// - table c: tx 8,16,32,56 rx 8,16,56,60
// - table d uses programmable trigger registers
// - six-bit priority codes from line status down
module uart_fctl_isr #(
  parameter int ADR_W      = 8,
  parameter int LEVEL_W    = 7,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DOC
) (
  input  wire logic               clk_i,             // 10 MHz clock
  input  wire logic               rst_i,             // sync reset, active high
  // wishbone classic slave
  input  wire logic               cyc_i,             // bus cycle
  input  wire logic               stb_i,             // strobe
  input  wire logic               we_i,              // write enable
  input  wire logic [ADR_W-1:0]   adr_i,             // byte address
  input  wire logic [31:0]        dat_i,             // write data
  input  wire logic [3:0]         sel_i,             // byte lanes
  output logic      [31:0]        dat_o,             // read data
  output logic                    ack_o,             // acknowledge
  // interrupt sources from the rest of the channel
  input  wire logic               lsr_int_i,         // line status error, level
  input  wire logic               rx_timeout_i,      // receive timeout, level
  input  wire logic               msr_int_i,         // modem status change, level
  input  wire logic               char_match_i,      // xon/xoff/special match, pulse
  input  wire logic               xon_rx_i,          // xon received, pulse
  input  wire logic               flow_change_i,     // flow pin changed, pulse
  input  wire logic               flow_clear_i,      // modem status read, pulse
  input  wire logic [LEVEL_W-1:0] rx_level_i,        // receive fifo level counter
  input  wire logic [LEVEL_W-1:0] tx_level_i,        // transmit fifo level counter
  // control toward the fifos
  output logic                    fifo_enable_o,     // both fifos enabled
  output logic                    rx_fifo_reset_o,   // clear rx pointers, pulse
  output logic                    tx_fifo_reset_o,   // clear tx pointers, pulse
  output logic                    rx_trigger_hit_o,  // rx level at trigger
  output logic                    isr_int_n_o        // any pending, active low
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // level counters must reach the full depth, and offsets must fit
  generate
    if (FIFO_DEPTH < 1 || FIFO_DEPTH > (1 << LEVEL_W) - 1) begin : g_bad_depth
      $error("fifo depth does not fit the level counter width");
    end
    if (LEVEL_W > 8 || LEVEL_W < 7) begin : g_bad_level
      $error("level width must hold trigger values up to 60");
    end
    if (ADR_W < 5) begin : g_bad_adr
      $error("address too narrow for the register map");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] fifo_control;          // stored control byte, reset bits read 0
  logic [7:0] feature_control_reg;   // table select in bits 7:6
  logic [7:0] enhanced_feature_reg;  // enhanced enable in bit 4
  logic [7:0] rx_trigger_level_reg;  // table d receive trigger
  logic [7:0] tx_trigger_level_reg;  // table d transmit trigger

  // sticky interrupt flags
  logic       tx_pending;
  logic       special_pending;
  logic       flow_pending;

  // transmit interrupt tracking
  logic [LEVEL_W-1:0] tx_level_prev;
  logic               tx_above_seen;

  // helper outputs
  logic [LEVEL_W-1:0] rx_trig;
  logic [LEVEL_W-1:0] tx_trig;
  logic [7:0]         isr_value;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // a request is accepted one cycle after it appears; the write and the read
  // side effects happen on the edge where ack is high, matching the master
  logic       bus_req;
  logic       wr_fire;
  logic       rd_fire;
  logic       lane0_wr;
  logic [7:0] wr_byte;
  logic       hit_isr;
  logic       hit_fctl;
  logic       hit_feat;
  logic       hit_enh;
  logic       hit_rxlvl;
  logic       hit_txlvl;

  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADR_W'(ofs));
  endfunction

  assign bus_req   = cyc_i & stb_i;
  assign wr_fire   = bus_req & we_i & ack_o;
  assign rd_fire   = bus_req & ~we_i & ack_o;
  assign lane0_wr  = wr_fire & sel_i[`LANE0];
  assign wr_byte   = dat_i[`BYTE0];
  assign hit_isr   = hit(adr_i, `OFS_ISR);
  assign hit_fctl  = hit(adr_i, `OFS_FCTL);
  assign hit_feat  = hit(adr_i, `OFS_FEAT);
  assign hit_enh   = hit(adr_i, `OFS_ENH);
  assign hit_rxlvl = hit(adr_i, `OFS_RXLVL);
  assign hit_txlvl = hit(adr_i, `OFS_TXLVL);

  // --------------------------------------------------------------------------
  // fifo control write decode
  // --------------------------------------------------------------------------
  // the enable bit always lands; the rest only ride along with enable set
  logic       fctl_wr;
  logic       fctl_en_in;
  logic [7:0] next_fifo_control;
  logic       next_rx_reset;
  logic       next_tx_reset;

  assign fctl_wr    = lane0_wr & hit_fctl;
  assign fctl_en_in = wr_byte[`FCTL_EN];
  assign next_fifo_control = !fctl_wr   ? fifo_control :
                             fctl_en_in ? {wr_byte[`FCTL_HOLD], 2'b00, 1'b1} :
                             {fifo_control[`FCTL_HOLD], 2'b00, 1'b0};
  assign next_rx_reset = fctl_wr & fctl_en_in & wr_byte[`FCTL_RXRST];
  assign next_tx_reset = fctl_wr & fctl_en_in & wr_byte[`FCTL_TXRST];

  // control byte and enable; the reset bits are never stored, so they read 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_control  <= `REG_RST;
      fifo_enable_o <= 1'b0;
    end else begin
      fifo_control  <= next_fifo_control;
      fifo_enable_o <= next_fifo_control[`FCTL_EN];
    end
  end

  // one-cycle pointer clears; shift registers are outside this block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_fifo_reset_o <= 1'b0;
      tx_fifo_reset_o <= 1'b0;
    end else begin
      rx_fifo_reset_o <= next_rx_reset;
      tx_fifo_reset_o <= next_tx_reset;
    end
  end

  // --------------------------------------------------------------------------
  // feature, enhanced and programmable trigger registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feature_control_reg  <= `REG_RST;
      enhanced_feature_reg <= `REG_RST;
      rx_trigger_level_reg <= `REG_RST;
      tx_trigger_level_reg <= `REG_RST;
    end else begin
      if (lane0_wr & hit_feat)  feature_control_reg  <= wr_byte;
      if (lane0_wr & hit_enh)   enhanced_feature_reg <= wr_byte;
      if (lane0_wr & hit_rxlvl) rx_trigger_level_reg <= wr_byte;
      if (lane0_wr & hit_txlvl) tx_trigger_level_reg <= wr_byte;
    end
  end

  // --------------------------------------------------------------------------
  // trigger lookup
  // --------------------------------------------------------------------------
  // a single table field feeds both directions, so they can never diverge
  uart_fctl_isr_pkg::trig_cfg_s trig_cfg;
  logic                         enh_en;

  assign trig_cfg.table_sel = feature_control_reg[`FEAT_TBL];
  assign trig_cfg.rx_sel    = fifo_control[`FCTL_RXT];
  assign trig_cfg.tx_sel    = fifo_control[`FCTL_TXT];
  assign trig_cfg.rx_prog   = rx_trigger_level_reg;
  assign trig_cfg.tx_prog   = tx_trigger_level_reg;
  assign enh_en             = enhanced_feature_reg[`ENH_BIT];

  trig_select #(
    .LEVEL_W   (LEVEL_W)
  ) u_trig (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cfg_i     (trig_cfg),
    .fifo_en_i (fifo_enable_o),
    .rx_trig_o (rx_trig),
    .tx_trig_o (tx_trig)
  );

  // --------------------------------------------------------------------------
  // receive data interrupt
  // --------------------------------------------------------------------------
  // a level, not a latch: it drops as soon as reads take the fifo below trigger
  logic rx_hit;

  assign rx_hit = (rx_level_i >= rx_trig) & (rx_level_i != LEVEL_W'(`LEVEL_ZERO));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_trigger_hit_o <= 1'b0;
    end else begin
      rx_trigger_hit_o <= rx_hit;
    end
  end

  // --------------------------------------------------------------------------
  // transmit interrupt
  // --------------------------------------------------------------------------
  // if the last reload never climbed past the trigger, waiting for a fall
  // below it would miss the event, so the empty edge raises it instead
  logic tx_below;
  logic tx_cross;
  logic tx_drain;
  logic tx_event;
  logic next_above_seen;

  assign tx_below = tx_level_i < tx_trig;
  assign tx_cross = tx_above_seen & tx_below;
  assign tx_drain = ~tx_above_seen & (tx_level_i == LEVEL_W'(`LEVEL_ZERO)) &
                    (tx_level_prev != LEVEL_W'(`LEVEL_ZERO));
  assign tx_event = tx_cross | tx_drain;
  assign next_above_seen = (tx_level_i > tx_trig) ? 1'b1 :
                           tx_cross               ? 1'b0 : tx_above_seen;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_level_prev <= '0;
      tx_above_seen <= 1'b0;
    end else begin
      tx_level_prev <= tx_level_i;
      tx_above_seen <= next_above_seen;
    end
  end

  // --------------------------------------------------------------------------
  // sticky flags
  // --------------------------------------------------------------------------
  // in every flag a new event on the clearing cycle wins over the clear
  logic isr_read;
  logic next_tx_pending;
  logic next_special;
  logic next_flow;

  assign isr_read        = rd_fire & hit_isr;
  assign next_tx_pending = tx_event | (tx_pending & ~isr_read);
  assign next_special    = (char_match_i & enh_en) | (special_pending & ~xon_rx_i);
  assign next_flow       = (flow_change_i & enh_en) | (flow_pending & ~flow_clear_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pending      <= 1'b0;
      special_pending <= 1'b0;
      flow_pending    <= 1'b0;
    end else begin
      tx_pending      <= next_tx_pending;
      special_pending <= next_special;
      flow_pending    <= next_flow;
    end
  end

  // --------------------------------------------------------------------------
  // status encoding
  // --------------------------------------------------------------------------
  uart_fctl_isr_pkg::int_src_s int_src;

  assign int_src.line_status = lsr_int_i;
  assign int_src.rx_data     = rx_trigger_hit_o;
  assign int_src.rx_timeout  = rx_timeout_i;
  assign int_src.tx_empty    = tx_pending;
  assign int_src.modem       = msr_int_i;
  assign int_src.special     = special_pending;
  assign int_src.flow        = flow_pending;

  isr_encoder u_enc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .src_i     (int_src),
    .enh_en_i  (enh_en),
    .fifo_en_i (fifo_enable_o),
    .isr_o     (isr_value)
  );

  // the pending output follows the status byte, one cycle behind its sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_int_n_o <= 1'b1;
    end else begin
      isr_int_n_o <= (int_src == '0) | ((int_src & ~{5'b0, ~enh_en, ~enh_en}) == '0);
    end
  end

  // --------------------------------------------------------------------------
  // read mux and acknowledge
  // --------------------------------------------------------------------------
  // unmapped addresses still ack and read zero so the master never hangs
  logic [7:0] rd_byte;

  assign rd_byte = hit_isr   ? isr_value :
                   hit_fctl  ? fifo_control :
                   hit_feat  ? feature_control_reg :
                   hit_enh   ? enhanced_feature_reg :
                   hit_rxlvl ? rx_trigger_level_reg :
                   hit_txlvl ? tx_trigger_level_reg : `REG_RST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `READ_ZERO;
    end else begin
      ack_o <= bus_req & ~ack_o;
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule // uart_fctl_isr
`default_nettype wire

//--- sim/uart_fcr_isr_assertions.sv
// port-level checks of the status and fifo control block
`timescale 1ns/1ps
`default_nettype none
module uart_fctl_isr_assertions #(
  parameter int ADR_W   = 8,
  parameter int LEVEL_W = 7
) (
  input wire logic               clk_i, rst_i,         // clock, sync reset
  input wire logic               cyc_i, stb_i, we_i,   // bus request
  input wire logic [ADR_W-1:0]   adr_i,                // byte address
  input wire logic [31:0]        dat_i, dat_o,         // write, read data
  input wire logic [3:0]         sel_i,                // byte lanes
  input wire logic               ack_o, lsr_int_i,     // ack, line status
  input wire logic [LEVEL_W-1:0] rx_level_i,           // rx fifo level
  input wire logic               fifo_enable_o,        // fifos on
  input wire logic               rx_fifo_reset_o,      // rx clear pulse
  input wire logic               tx_fifo_reset_o,      // tx clear pulse
  input wire logic               rx_trigger_hit_o,     // rx trigger
  input wire logic               isr_int_n_o           // pending, low
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a control write is the acked edge of a lane-0 write to offset 0x04
  wire wr_fctl = ack_o && we_i && adr_i == 8'h04 && sel_i[0];
  wire rd_isr = ack_o && !we_i && adr_i == 8'h00;

  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_fifo_enable: assert property (
    wr_fctl |=> fifo_enable_o == $past(dat_i[0])) else $error("fifo enable wrong");
  a_rx_clear: assert property (
    wr_fctl |=> rx_fifo_reset_o == $past(dat_i[0] && dat_i[1])) else $error("rx clear wrong");
  a_tx_clear: assert property (
    wr_fctl |=> tx_fifo_reset_o == $past(dat_i[0] && dat_i[2])) else $error("tx clear wrong");
  a_clear_once: assert property (
    rx_fifo_reset_o || tx_fifo_reset_o |=> !rx_fifo_reset_o && !tx_fifo_reset_o) else $error("clear stuck");
  a_isr_fifo: assert property (
    rd_isr |-> dat_o[7:6] == {2{fifo_enable_o}}) else $error("fifo status bits wrong");
  a_pend_low: assert property (lsr_int_i [*3] |-> !isr_int_n_o) else $error("pending not shown");
  a_idle_high: assert property ($fell(rst_i) |-> isr_int_n_o) else $error("reset not idle");
  a_empty_no_hit: assert property (
    (rx_level_i == 7'h00) [*2] |-> !rx_trigger_hit_o) else $error("hit on empty fifo");
endmodule // uart_fctl_isr_assertions
bind uart_fctl_isr uart_fctl_isr_assertions #(.ADR_W(ADR_W), .LEVEL_W(LEVEL_W)) chk (.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .sel_i, .ack_o, .lsr_int_i, .rx_level_i,
  .fifo_enable_o, .rx_fifo_reset_o, .tx_fifo_reset_o, .rx_trigger_hit_o, .isr_int_n_o);
`default_nettype wire

//--- sim/host_model.sv
// host software model: classic wishbone master for register access
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_i,         // bus clock
  input  wire logic        ack_i,         // slave acknowledge
  input  wire logic [31:0] dat_i,         // read data
  output logic             cyc_o = 1'b0,  // cycle
  output logic             stb_o = 1'b0,  // strobe
  output logic             we_o  = 1'b0,  // write
  output logic [7:0]       adr_o = 8'h00, // address
  output logic [31:0]      dat_o = 32'h0, // write data
  output logic [3:0]       sel_o = 4'h0   // lanes
);
  // request held until ack is sampled; released lines carry the inverse
  // so a stale address or data never looks like a live request
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} <= {2'h3, w, a, d, 4'h1};
    // no cycle limit of its own: only the bench timeout ends a lost answer
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h0, ~w, ~a, ~d};
    #1;
  endtask
endmodule // host_model
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the status and fifo control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc, stb, we, ack, fen, rrst, trst, hit, int_n;
  logic [7:0]  adr, lfsr = 8'h16;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  logic [6:0]  src = 7'h00, rxl = 7'h00, txl = 7'h00, lv, e;
  logic [1:0]  t, s;
  int          miscompares = 0, cmp_count = 0, cycles = 0;
  logic [2:0]  msk [5] = '{3'h7, 3'h3, 3'h3, 3'h1, 3'h0};
  logic [7:0]  isr [5] = '{8'hc6, 8'hc4, 8'hcc, 8'hc0, 8'hc1};

  initial forever #50 clk_i = ~clk_i;
  host_model host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .dat_o(wdat), .sel_o(sel));
  uart_fctl_isr dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .sel_i(sel), .dat_o(rdat), .ack_o(ack), .lsr_int_i(src[6]), .rx_timeout_i(src[5]), .msr_int_i(src[4]),
    .char_match_i(src[3]), .xon_rx_i(src[2]), .flow_change_i(src[1]), .flow_clear_i(src[0]),
    .rx_level_i(rxl), .tx_level_i(txl), .fifo_enable_o(fen), .rx_fifo_reset_o(rrst),
    .tx_fifo_reset_o(trst), .rx_trigger_hit_o(hit), .isr_int_n_o(int_n));

  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // receive trigger per table and select; table d uses the programmed 5
  function automatic logic [6:0] rx_trig(logic [1:0] tb, logic [1:0] sl);
    logic [111:0] lut;
    lut = {{4{7'h05}}, 7'h3c, 7'h38, 7'h10, 7'h08, 7'h1c, 7'h18, 7'h10, 7'h08, 7'h0e, 7'h08, 7'h04, 7'h01};
    return lut[(int'(tb) * 4 + int'(sl)) * 7 +: 7];
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    host.bus(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x);
    host.bus(1'b0, a, 32'h0, q);
    `CHK(q, {24'h0, x})
  endtask
  task automatic pulse(int b);
    @(posedge clk_i);
    src[b] <= 1'b1;
    @(posedge clk_i);
    src[b] <= 1'b0;
    tick(3);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    `CHK(int_n, 1'b1)
    rd(8'h00, 8'h01);
    rd(8'h04, 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h04, 8'hcf);
    `CHK({rrst, trst, fen}, 3'h7)
    tick(1);
    `CHK({rrst, trst}, 2'h0)
    rd(8'h04, 8'hc9);
    rd(8'h00, 8'hc1);
    wr(8'h04, 8'h36);
    `CHK({rrst, trst, fen}, 3'h0)
    rd(8'h04, 8'hc8);
    rd(8'h00, 8'h01);
    wr(8'h10, 8'h05);
    // every table and select, with levels just under, at, or random
    for (int i = 0; i < 32; i++) begin
      lfsr = nxt(lfsr);
      t = 2'(i % 16 / 4);
      s = 2'(i % 4);
      e = rx_trig(t, s);
      wr(8'h08, {t, 6'h00});
      wr(8'h04, {s, 6'h01});
      lv = lfsr[0] ? e - 7'h01 + 7'(lfsr[1]) : {1'b0, lfsr[7:2]};
      @(posedge clk_i);
      rxl <= lv;
      tick(3);
      `CHK(hit, (lv >= e) && (lv != 7'h00))
    end
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h01);
    // priority walk, highest source removed step by step
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      src[6:4] <= msk[k];
      rxl <= 7'(k < 2);
      tick(4);
      `CHK(int_n, 1'(k == 4))
      rd(8'h00, isr[k]);
    end
    wr(8'h0c, 8'h10);
    pulse(3);
    rd(8'h00, 8'hd0);
    rd(8'h00, 8'hd0);
    wr(8'h0c, 8'h00);
    rd(8'h00, 8'hc1);
    wr(8'h0c, 8'h10);
    pulse(1);
    rd(8'h00, 8'hd0);
    pulse(2);
    rd(8'h00, 8'he0);
    pulse(0);
    rd(8'h00, 8'hc1);
    wr(8'h08, 8'h40);
    @(posedge clk_i);
    txl <= 7'h14;
    tick(3);
    @(posedge clk_i);
    txl <= 7'h0a;
    tick(3);
    rd(8'h00, 8'hc2);
    rd(8'h00, 8'hc1);
    @(posedge clk_i);
    txl <= 7'h05;
    tick(3);
    rd(8'h00, 8'hc1);
    @(posedge clk_i);
    txl <= 7'h00;
    tick(3);
    rd(8'h00, 8'hc2);
    rd(8'h10, 8'h05);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
